// File: pkg/dmal_params.svh
/*
  Constants of the diagnostic monitor and alarm logic: register offsets, field positions,
  reset values and timing counts. Assumes it is included by the package and the design files.
*/
`ifndef DMAL_PARAMS_SVH
`define DMAL_PARAMS_SVH

// address spaces of the byte register port
`define DMAL_SPACE_USER 2'h0
`define DMAL_SPACE_OEM 2'h1

// user space (status, results, masks)
`define DMAL_TEMP_MSB 8'h60
`define DMAL_TEMP_LSB 8'h61
`define DMAL_AUX_RES 8'h62
`define DMAL_BIAS_RES 8'h64
`define DMAL_MPD_RES 8'h66
`define DMAL_RX_MSB 8'h68
`define DMAL_RX_LSB 8'h69
`define DMAL_ALARM_FLAG_A 8'h70
`define DMAL_ALARM_FLAG_B 8'h71
`define DMAL_WARN_FLAG_A 8'h74
`define DMAL_WARN_FLAG_B 8'h75
`define DMAL_ALARM_MASK_A 8'hF8
`define DMAL_ALARM_MASK_B 8'hF9
`define DMAL_WARN_MASK_A 8'hFA
`define DMAL_WARN_MASK_B 8'hFB

// OEM space (configuration, offset table)
`define DMAL_OEM_CONFIG_0 8'h00
`define DMAL_OEM_CONFIG_1 8'h01
`define DMAL_OEM_CONFIG_4 8'h19
`define DMAL_TCO_FIRST 8'h60
`define DMAL_TCO_LAST 8'h86
`define DMAL_TCO_ENTRIES 39

// field positions
`define DMAL_CFG0_GAIN 3
`define DMAL_CFG1_REFSEL 0
`define DMAL_CFG4_TEMP9 0
`define DMAL_CFG4_OFS_REPORT 1
`define DMAL_CFG4_OFS_COMP 2
`define DMAL_CFG4_ALARM_TRACK 4
`define DMAL_CFG4_WARN_TRACK 5
`define DMAL_CFG4_ALARM_FAULT 6
`define DMAL_CFG4_WARN_FAULT 7
`define DMAL_MASK_B_USED 8'hC0

// reset values; received-power-low mask is set
`define DMAL_MASK_RST 10'h001
`define DMAL_CFG_RST 8'h00

// temperature bands of the offset table, degrees
`define DMAL_TCO_LOW_LIMIT -45
`define DMAL_TCO_BAND_BASE 44
`define DMAL_TCO_HIGH_LIMIT 104

// conversion cycle
`define DMAL_CLK_MHZ 20
`define DMAL_T_CONV_US 100
`define DMAL_CONV_CYCLES (`DMAL_T_CONV_US * `DMAL_CLK_MHZ)

`endif

// File: pkg/dmal_pkg.sv
/*
  Types of the diagnostic monitor and alarm logic.
  Assumes dmal_params.svh sits beside it on the include path.
*/
`include "dmal_params.svh"

package dmal_pkg;

  typedef enum logic [2:0] {
    DMAL_CH_TEMP = 3'h0,
    DMAL_CH_AUX = 3'h1,
    DMAL_CH_MPD = 3'h2,
    DMAL_CH_BIAS = 3'h3,
    DMAL_CH_RX = 3'h4
  } dmal_chan_t;

  typedef enum logic [2:0] {
    DMAL_SEQ_IDLE = 3'b001,
    DMAL_SEQ_START = 3'b010,
    DMAL_SEQ_WAIT = 3'b100
  } dmal_seq_state_t;

  typedef struct packed {
    logic [1:0] space;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dmal_reg_req_t;

  typedef struct packed {
    logic start;
    dmal_chan_t chan;
    logic [2:0] aux_sel;
    logic gain;
    logic ref_sel;
  } dmal_adc_ctl_t;

  typedef struct packed {
    logic [9:0] alarm;
    logic [9:0] warn;
  } dmal_cond_t;

endpackage : dmal_pkg

// File: rtl/dmal_adc_seq.sv
/*
  Round-robin sequencer of the shared converter over the five monitored channels.
  Assumes the converter answers each start with one done pulse, well inside a conversion cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmal_params.svh"

module dmal_adc_seq
  import dmal_pkg::*;
#(
  parameter int CONV_CYCLES = `DMAL_CONV_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // converter handshake
  input wire logic adc_done,
  output logic start_r,
  output dmal_chan_t chan_r
);

  localparam int CW = $clog2(CONV_CYCLES);

  dmal_seq_state_t state_r;
  logic [CW-1:0] div_r;
  wire tick = (div_r == '0);
  wire last_chan = (chan_r == DMAL_CH_RX);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_r <= '0;
    else
      div_r <= tick ? CW'(CONV_CYCLES - 1) : div_r - 1'b1;
  end

  // one pass per tick, channels in fixed order
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= DMAL_SEQ_IDLE;
      chan_r <= DMAL_CH_TEMP;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      unique case (state_r)
        DMAL_SEQ_IDLE:
          if (tick)
          begin
            chan_r <= DMAL_CH_TEMP;
            state_r <= DMAL_SEQ_START;
          end
        DMAL_SEQ_START:
        begin
          start_r <= 1'b1;
          state_r <= DMAL_SEQ_WAIT;
        end
        DMAL_SEQ_WAIT:
          if (adc_done)
          begin
            if (last_chan)
              state_r <= DMAL_SEQ_IDLE;
            else
            begin
              chan_r <= dmal_chan_t'(chan_r + 3'h1);
              state_r <= DMAL_SEQ_START;
            end
          end
      endcase
    end
  end

  sequence s_conv_done;
    state_r == DMAL_SEQ_WAIT && adc_done && !last_chan;
  endsequence

  sequence s_next_start;
    ##1 state_r == DMAL_SEQ_START ##1 start_r;
  endsequence

  a_round_robin: assert property (@(posedge clk) disable iff (!rstn)
    s_conv_done |-> s_next_start)
    else $error("next channel not started after a conversion");

  a_pass_in_cycle: assert property (@(posedge clk) disable iff (!rstn)
    tick |-> state_r == DMAL_SEQ_IDLE)
    else $error("pass still running at next conversion cycle");

endmodule : dmal_adc_seq

`default_nettype wire

// File: rtl/dmal_temp_offset.sv
/*
  Chip-to-case temperature offset: band index from the sensed temperature and the sum.
  Assumes temperature and offset in signed half-degree units; the table is held by the caller.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmal_params.svh"

module dmal_temp_offset
  import dmal_pkg::*;
(
  // sensed temperature and selected entry
  input wire logic signed [8:0] temp_raw,
  input wire logic signed [7:0] entry,
  // band index and corrected temperature
  output logic [5:0] idx,
  output logic signed [8:0] temp_adj
);

  wire signed [7:0] t_deg = 8'(temp_raw >>> 1);
  wire signed [8:0] t_band = 9'(t_deg + 9'sd`DMAL_TCO_BAND_BASE);
  wire signed [9:0] sum = 10'(temp_raw) + 10'(entry);

  // bands of four degrees from -44, clamped at both ends
  assign idx = (t_deg <= 8'(`DMAL_TCO_LOW_LIMIT)) ? 6'h00 :
               (t_deg >= 8'sd`DMAL_TCO_HIGH_LIMIT) ? 6'(`DMAL_TCO_ENTRIES - 1) :
               6'(t_band[8:2] + 7'h01);

  // entries are half-degree units, same as the sensed value; saturate
  assign temp_adj = (sum > 10'sd255) ? 9'sh0FF :
                    (sum < -10'sd256) ? 9'sh100 : sum[8:0];

endmodule : dmal_temp_offset

`default_nettype wire

// File: rtl/dmal_monitor.sv
/*
  Diagnostic monitor and alarm logic: converter sequencing, result store, case offset
  table, alarm and warning flags, interrupt and transmit-fault sourcing.
  Assumes a byte register port decoded from the serial interface, synchronous inputs,
  and threshold comparison done upstream (condition levels in).
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmal_params.svh"

module dmal_monitor
  import dmal_pkg::*;
#(
  parameter int CONV_CYCLES = `DMAL_CONV_CYCLES,
  parameter int NSRC = 10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // byte register port
  input wire dmal_reg_req_t reg_req,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  // converter
  output dmal_adc_ctl_t adc_ctl,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  // mode and conditions
  input wire logic oem_mode,
  input wire dmal_cond_t cond,
  input wire logic tx_disable_input,
  // outputs
  output logic interrupt_r,
  output logic tx_fault_output_r,
  output logic signed [8:0] comp_temp_r
);

  // configuration and masks
  logic [7:0] oem_config_0_r;
  logic [7:0] oem_config_1_r;
  logic [7:0] oem_config_4_r;
  logic [NSRC-1:0] alarm_mask_r;
  logic [NSRC-1:0] warn_mask_r;
  logic [7:0] tco_table_r [0:`DMAL_TCO_ENTRIES-1];

  // results and flags
  logic signed [8:0] temp_report_r;
  logic [7:0] aux_res_r;
  logic [7:0] mpd_res_r;
  logic [7:0] bias_res_r;
  logic [11:0] rx_res_r;
  logic [NSRC-1:0] alarm_flag_r;
  logic [NSRC-1:0] warn_flag_r;
  logic [NSRC-1:0] alarm_prev_r;
  logic [NSRC-1:0] warn_prev_r;
  logic txd_prev_r;
  logic [2:0] aux_sel_r;
  logic gain_r;
  logic ref_sel_r;
  logic seq_start;
  dmal_chan_t seq_chan;

  // register decode
  wire sp_user = (reg_req.space == `DMAL_SPACE_USER);
  wire sp_oem = (reg_req.space == `DMAL_SPACE_OEM);
  wire wr_user = reg_req.wr && sp_user;
  wire wr_oem = reg_req.wr && sp_oem;
  wire rd_user = reg_req.rd && sp_user;
  wire in_tco = (reg_req.addr >= `DMAL_TCO_FIRST) && (reg_req.addr <= `DMAL_TCO_LAST);
  wire [5:0] tco_waddr = 6'(reg_req.addr - `DMAL_TCO_FIRST);

  // flag clears: read of a flag byte, or transmit-disable toggle
  wire txd_toggle = (tx_disable_input != txd_prev_r);
  wire rd_af_a = rd_user && (reg_req.addr == `DMAL_ALARM_FLAG_A);
  wire rd_af_b = rd_user && (reg_req.addr == `DMAL_ALARM_FLAG_B);
  wire rd_wf_a = rd_user && (reg_req.addr == `DMAL_WARN_FLAG_A);
  wire rd_wf_b = rd_user && (reg_req.addr == `DMAL_WARN_FLAG_B);
  wire [NSRC-1:0] alarm_clr = {{8{rd_af_a}}, {2{rd_af_b}}} | {NSRC{txd_toggle}};
  wire [NSRC-1:0] warn_clr = {{8{rd_wf_a}}, {2{rd_wf_b}}} | {NSRC{txd_toggle}};
  wire alarm_track = oem_config_4_r[`DMAL_CFG4_ALARM_TRACK];
  wire warn_track = oem_config_4_r[`DMAL_CFG4_WARN_TRACK];

  // flag update, one stage per source; set wins over clear
  logic [NSRC-1:0] alarm_flag_nxt;
  logic [NSRC-1:0] warn_flag_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_flag
      // tracking mode: set on a new condition, drop when it goes or is cleared
      assign alarm_flag_nxt[gi] = alarm_track ?
        ((cond.alarm[gi] && !alarm_prev_r[gi]) || (alarm_flag_r[gi] && cond.alarm[gi] && !alarm_clr[gi])) :
        (cond.alarm[gi] || (alarm_flag_r[gi] && !alarm_clr[gi]));
      assign warn_flag_nxt[gi] = warn_track ?
        ((cond.warn[gi] && !warn_prev_r[gi]) || (warn_flag_r[gi] && cond.warn[gi] && !warn_clr[gi])) :
        (cond.warn[gi] || (warn_flag_r[gi] && !warn_clr[gi]));
    end
  endgenerate

  // interrupt and fault sources
  wire [NSRC-1:0] alarm_open = alarm_flag_nxt & ~alarm_mask_r;
  wire [NSRC-1:0] warn_open = warn_flag_nxt & ~warn_mask_r;
  wire irq_nxt = |alarm_open || |warn_open;
  wire fault_nxt = (oem_config_4_r[`DMAL_CFG4_ALARM_FAULT] && |alarm_open) ||
                   (oem_config_4_r[`DMAL_CFG4_WARN_FAULT] && |warn_open);

  // converter steering; code 111 has no node and falls back to the supply
  wire [2:0] aux_req = oem_config_0_r[2:0];
  wire [2:0] aux_nxt = (oem_mode && aux_req != 3'h7) ? aux_req : 3'h0;

  // temperature: 9-bit half degrees, or 8-bit whole degrees shifted up
  wire signed [8:0] temp_raw = oem_config_4_r[`DMAL_CFG4_TEMP9] ?
                               adc_data[8:0] : {adc_data[7:0], 1'b0};
  logic [5:0] tco_idx;
  logic signed [8:0] temp_adj;
  wire [7:0] tco_entry = tco_table_r[tco_idx];
  wire res_we = adc_done;

  // read mux
  logic [7:0] rd_user_data;
  logic [7:0] rd_oem_data;
  always_comb
  begin
    rd_user_data = 8'h00;
    unique case (reg_req.addr)
      `DMAL_TEMP_MSB: rd_user_data = temp_report_r[8:1];
      `DMAL_TEMP_LSB: rd_user_data = {temp_report_r[0], 7'h00};
      `DMAL_AUX_RES: rd_user_data = aux_res_r;
      `DMAL_MPD_RES: rd_user_data = mpd_res_r;
      `DMAL_BIAS_RES: rd_user_data = bias_res_r;
      `DMAL_RX_MSB: rd_user_data = rx_res_r[11:4];
      `DMAL_RX_LSB: rd_user_data = {rx_res_r[3:0], 4'h0};
      `DMAL_ALARM_FLAG_A: rd_user_data = alarm_flag_r[9:2];
      `DMAL_ALARM_FLAG_B: rd_user_data = {alarm_flag_r[1:0], 6'h00};
      `DMAL_WARN_FLAG_A: rd_user_data = warn_flag_r[9:2];
      `DMAL_WARN_FLAG_B: rd_user_data = {warn_flag_r[1:0], 6'h00};
      `DMAL_ALARM_MASK_A: rd_user_data = alarm_mask_r[9:2];
      `DMAL_ALARM_MASK_B: rd_user_data = {alarm_mask_r[1:0], 6'h00};
      `DMAL_WARN_MASK_A: rd_user_data = warn_mask_r[9:2];
      `DMAL_WARN_MASK_B: rd_user_data = {warn_mask_r[1:0], 6'h00};
      default: rd_user_data = 8'h00;
    endcase
  end

  always_comb
  begin
    rd_oem_data = 8'h00;
    if (in_tco)
      rd_oem_data = tco_table_r[tco_waddr];
    else if (reg_req.addr == `DMAL_OEM_CONFIG_0)
      rd_oem_data = oem_config_0_r;
    else if (reg_req.addr == `DMAL_OEM_CONFIG_1)
      rd_oem_data = oem_config_1_r;
    else if (reg_req.addr == `DMAL_OEM_CONFIG_4)
      rd_oem_data = oem_config_4_r;
  end

  dmal_adc_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .clk(clk),
    .rstn(rstn),
    .adc_done(adc_done),
    .start_r(seq_start),
    .chan_r(seq_chan)
  );

  dmal_temp_offset u_tco (
    .temp_raw(temp_raw),
    .entry(tco_entry),
    .idx(tco_idx),
    .temp_adj(temp_adj)
  );

  assign adc_ctl = '{start: seq_start, chan: seq_chan, aux_sel: aux_sel_r, gain: gain_r, ref_sel: ref_sel_r};

  // configuration and masks; reserved mask bits are not stored
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oem_config_0_r <= `DMAL_CFG_RST;
      oem_config_1_r <= `DMAL_CFG_RST;
      oem_config_4_r <= `DMAL_CFG_RST;
      alarm_mask_r <= `DMAL_MASK_RST;
      warn_mask_r <= `DMAL_MASK_RST;
    end
    else
    begin
      if (wr_oem && reg_req.addr == `DMAL_OEM_CONFIG_0)
        oem_config_0_r <= reg_req.wdata;
      if (wr_oem && reg_req.addr == `DMAL_OEM_CONFIG_1)
        oem_config_1_r <= reg_req.wdata;
      if (wr_oem && reg_req.addr == `DMAL_OEM_CONFIG_4)
        oem_config_4_r <= reg_req.wdata;
      if (wr_user && reg_req.addr == `DMAL_ALARM_MASK_A)
        alarm_mask_r[9:2] <= reg_req.wdata;
      if (wr_user && reg_req.addr == `DMAL_ALARM_MASK_B)
        alarm_mask_r[1:0] <= reg_req.wdata[7:6];
      if (wr_user && reg_req.addr == `DMAL_WARN_MASK_A)
        warn_mask_r[9:2] <= reg_req.wdata;
      if (wr_user && reg_req.addr == `DMAL_WARN_MASK_B)
        warn_mask_r[1:0] <= reg_req.wdata[7:6];
    end
  end

  // offset table is plain storage, no reset, so it maps to a small memory
  always_ff @(posedge clk)
  begin
    if (wr_oem && in_tco)
      tco_table_r[tco_waddr] <= reg_req.wdata;
  end

  // result store, written as each conversion lands
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      temp_report_r <= '0;
      comp_temp_r <= '0;
      aux_res_r <= 8'h00;
      mpd_res_r <= 8'h00;
      bias_res_r <= 8'h00;
      rx_res_r <= 12'h000;
    end
    else if (res_we)
    begin
      unique case (seq_chan)
        DMAL_CH_TEMP:
        begin
          temp_report_r <= oem_config_4_r[`DMAL_CFG4_OFS_REPORT] ? temp_adj : temp_raw;
          comp_temp_r <= oem_config_4_r[`DMAL_CFG4_OFS_COMP] ? temp_adj : temp_raw;
        end
        DMAL_CH_AUX: aux_res_r <= adc_data[7:0];
        DMAL_CH_MPD: mpd_res_r <= adc_data[7:0];
        DMAL_CH_BIAS: bias_res_r <= adc_data[7:0];
        DMAL_CH_RX: rx_res_r <= adc_data;
        default: rx_res_r <= rx_res_r;
      endcase
    end
  end

  // flags, outputs, converter controls
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alarm_flag_r <= '0;
      warn_flag_r <= '0;
      alarm_prev_r <= '0;
      warn_prev_r <= '0;
      txd_prev_r <= 1'b0;
      interrupt_r <= 1'b0;
      tx_fault_output_r <= 1'b0;
      aux_sel_r <= 3'h0;
      gain_r <= 1'b0;
      ref_sel_r <= 1'b0;
    end
    else
    begin
      alarm_flag_r <= alarm_flag_nxt;
      warn_flag_r <= warn_flag_nxt;
      alarm_prev_r <= cond.alarm;
      warn_prev_r <= cond.warn;
      txd_prev_r <= tx_disable_input;
      interrupt_r <= irq_nxt;
      tx_fault_output_r <= fault_nxt;
      aux_sel_r <= aux_nxt;
      gain_r <= oem_config_0_r[`DMAL_CFG0_GAIN];
      ref_sel_r <= oem_config_1_r[`DMAL_CFG1_REFSEL];
    end
  end

  // register read answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata_r <= sp_user ? rd_user_data : (sp_oem ? rd_oem_data : 8'h00);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_irq_masked: assert property (((alarm_open == '0) && (warn_open == '0)) |=> !interrupt_r)
    else $error("interrupt with every flag masked");

  a_irq_held: assert property ((alarm_flag_r[9] && !alarm_mask_r[9] && !alarm_clr[9] &&
    (!alarm_track || cond.alarm[9])) |=> interrupt_r)
    else $error("interrupt dropped while unmasked flag set");

  a_alarm_latch: assert property ((!alarm_track && alarm_flag_r[9] && !alarm_clr[9]) |=> alarm_flag_r[9])
    else $error("latched alarm flag lost without clear");

  a_alarm_follow: assert property ((alarm_track && !cond.alarm[9]) |=> !alarm_flag_r[9])
    else $error("tracking alarm flag outlived its condition");

  a_warn_follow: assert property ((warn_track && !cond.warn[9]) |=> !warn_flag_r[9])
    else $error("tracking warning flag outlived its condition");

  a_fault_off: assert property ((oem_config_4_r[7:6] == 2'b00) |=> !tx_fault_output_r)
    else $error("transmit fault raised with sources disabled");

  a_fault_mask: assert property ((oem_config_4_r[7:6] == 2'b01 &&
    ((alarm_flag_r | cond.alarm) & ~alarm_mask_r) == '0) |=> !tx_fault_output_r)
    else $error("masked alarm reached transmit fault");

  a_mask_resv: assert property ((rd_user && reg_req.addr == `DMAL_WARN_MASK_B) |=> reg_rdata_r[5:0] == 6'h00)
    else $error("reserved mask bits read nonzero");

  a_aux_locked: assert property (!oem_mode |=> adc_ctl.aux_sel == 3'h0)
    else $error("aux channel redirected outside OEM mode");

  a_read_clear: assert property ((rd_af_a && !alarm_track && cond.alarm[9:2] == '0) |=> alarm_flag_r[9:2] == '0)
    else $error("alarm flags survived a read");

  a_band_low: assert property ((temp_raw <= -9'sd90) |-> tco_idx == 6'h00)
    else $error("cold temperature not on entry zero");

endmodule : dmal_monitor

`default_nettype wire

// File: test/dmal_adc_model.sv
/*
  Converter model: one done pulse with a per-channel value after each start.
  Assumes start lasts one cycle and chan holds until done.
*/
`timescale 1ns/1ns
`default_nettype none

module dmal_adc_model
  import dmal_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // converter side
  input wire dmal_adc_ctl_t adc_ctl,
  input wire logic [3:0] lat,
  input wire logic [11:0] temp_val,
  input wire logic [11:0] rx_val,
  output logic adc_done,
  output logic [11:0] adc_data
);
  int cnt;
  // data toggles outside done so a stale value never passes for a result
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt = 0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end
    else
    begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_ctl.start)
        cnt = 32'(lat) + 1;
      else if (cnt > 0)
      begin
        cnt = cnt - 1;
        if (cnt == 0)
        begin
          adc_done <= 1'b1;
          adc_data <= (adc_ctl.chan == DMAL_CH_TEMP) ? temp_val : ((adc_ctl.chan == DMAL_CH_RX) ? rx_val : 12'h0A5);
        end
      end
    end
  end
endmodule : dmal_adc_model

`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench of the monitor: byte register port tasks and scenario calls.
  Assumes the converter model beside the design and a 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmal_params.svh"

module tb
  import dmal_pkg::*;
;
  localparam int CONV = 64;
  localparam logic [1:0] US = `DMAL_SPACE_USER;
  localparam logic [1:0] OS = `DMAL_SPACE_OEM;
  logic clk;
  logic rstn;
  dmal_reg_req_t reg_req;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r;
  dmal_adc_ctl_t adc_ctl;
  dmal_adc_ctl_t ctl;
  logic adc_done;
  logic [11:0] adc_data;
  logic oem_mode;
  dmal_cond_t cond;
  logic tx_disable_input;
  logic interrupt_r;
  logic tx_fault_output_r;
  logic signed [8:0] comp_temp_r;
  logic [3:0] lat;
  logic [11:0] temp_val;
  logic [11:0] rx_val;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ts;
  int t0;
  int tv[5] = '{-90, -88, 206, 208, 50};
  int te[5] = '{0, 1, 37, 38, 18};

  dmal_monitor #(.CONV_CYCLES(CONV)) i_dut (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .adc_ctl(adc_ctl), .adc_done(adc_done),
    .adc_data(adc_data), .oem_mode(oem_mode), .cond(cond), .tx_disable_input(tx_disable_input),
    .interrupt_r(interrupt_r), .tx_fault_output_r(tx_fault_output_r), .comp_temp_r(comp_temp_r));
  dmal_adc_model i_adc (.clk(clk), .rstn(rstn), .adc_ctl(adc_ctl), .lat(lat), .temp_val(temp_val),
    .rx_val(rx_val), .adc_done(adc_done), .adc_data(adc_data));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic cb(input string what, input logic exp, input logic got);
    cmp(what, {11'h000, exp}, {11'h000, got});
  endtask : cb

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // requests rest one idle edge so a strobe is never raised twice in one step
  task automatic wr(input logic [1:0] sp, input logic [7:0] a, input logic [7:0] d);
    reg_req = '{sp, a, 1'b1, 1'b0, d};
    wt(1);
    reg_req.wr = 1'b0;
    wt(1);
  endtask : wr

  task automatic chk(input logic [1:0] sp, input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{sp, a, 1'b0, 1'b1, 8'h00};
    wt(1);
    reg_req.rd = 1'b0;
    cb("rvalid", 1'b1, reg_rvalid_r);
    cmp($sformatf("reg %h", a), {4'h0, exp}, {4'h0, reg_rdata_r});
    wt(1);
  endtask : chk

  task automatic nxt();
    int n;
    n = 0;
    while (adc_ctl.start !== 1'b1)
    begin
      wt(1);
      n++;
      if (n > 300)
      begin
        mismatches++;
        close_out();
      end
    end
    ctl = adc_ctl;
    ts = cyc;
    wt(1);
  endtask : nxt

  task automatic find(input dmal_chan_t c);
    nxt();
    repeat (6)
      if (ctl.chan !== c)
        nxt();
  endtask : find

  initial
  begin
    rstn = 1'b0;
    reg_req = '0;
    oem_mode = 1'b0;
    cond = '0;
    tx_disable_input = 1'b0;
    lat = 4'h1;
    temp_val = 12'h000;
    rx_val = 12'hABC;
    wt(10);
    rstn = 1'b1;
    wt(1);
    for (int k = 0; k < 4; k++)
      chk(US, `DMAL_ALARM_MASK_A + 8'(k), k[0] ? 8'h40 : 8'h00);
    cond.alarm = 10'h001;
    wt(2);
    cb("irq", 1'b0, interrupt_r);
    chk(US, `DMAL_ALARM_FLAG_B, 8'h40);
    cond.alarm = 10'h000;
    wt(2);
    chk(US, `DMAL_ALARM_FLAG_B, 8'h40);
    chk(US, `DMAL_ALARM_FLAG_B, 8'h00);
    wr(US, `DMAL_ALARM_MASK_B, 8'hFF);
    chk(US, `DMAL_ALARM_MASK_B, 8'hC0);
    wr(US, `DMAL_WARN_MASK_B, 8'hFF);
    chk(US, `DMAL_WARN_MASK_B, 8'hC0);
    cond.warn = 10'h200;
    wt(2);
    cb("irq", 1'b1, interrupt_r);
    wr(US, `DMAL_WARN_MASK_A, 8'h80);
    cb("irq", 1'b0, interrupt_r);
    wr(US, `DMAL_WARN_MASK_A, 8'h00);
    cond.warn = 10'h000;
    wt(2);
    cb("irq", 1'b1, interrupt_r);
    tx_disable_input = 1'b1;
    wt(2);
    cb("irq", 1'b0, interrupt_r);
    chk(US, `DMAL_WARN_FLAG_A, 8'h00);
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h30);
    cond = '{10'h200, 10'h200};
    wt(2);
    cb("irq", 1'b1, interrupt_r);
    cond = '0;
    wt(2);
    cb("irq", 1'b0, interrupt_r);
    chk(US, `DMAL_ALARM_FLAG_A, 8'h00);
    chk(US, `DMAL_WARN_FLAG_A, 8'h00);
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h00);
    cond.alarm = 10'h200;
    wt(2);
    cb("fault", 1'b0, tx_fault_output_r);
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h40);
    cb("fault", 1'b1, tx_fault_output_r);
    wr(US, `DMAL_ALARM_MASK_A, 8'h80);
    cb("fault", 1'b0, tx_fault_output_r);
    cond.alarm = 10'h000;
    wt(2);
    chk(US, `DMAL_ALARM_FLAG_A, 8'h80);
    chk(US, `DMAL_ALARM_FLAG_A, 8'h00);
    cond = '{10'h000, 10'h200};
    tx_disable_input = 1'b0;
    wt(2);
    cb("fault", 1'b0, tx_fault_output_r);
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h80);
    cb("fault", 1'b1, tx_fault_output_r);
    cond = '0;
    oem_mode = 1'b1;
    for (int k = 0; k < 7; k++)
    begin
      wr(OS, `DMAL_OEM_CONFIG_0, 8'(k + 8 * (k % 2)));
      find(DMAL_CH_AUX);
      cmp("aux", 12'(k), 12'(ctl.aux_sel));
      cb("gain", k[0], ctl.gain);
    end
    oem_mode = 1'b0;
    wr(OS, `DMAL_OEM_CONFIG_1, 8'h01);
    find(DMAL_CH_AUX);
    cmp("aux", 12'h000, 12'(ctl.aux_sel));
    cb("ref", 1'b1, ctl.ref_sel);
    // slow converter: the pass must still keep its fixed period
    lat = 4'h6;
    find(DMAL_CH_TEMP);
    t0 = ts;
    for (int k = 1; k < 5; k++)
    begin
      nxt();
      cmp("chan", 12'(k), 12'(ctl.chan));
    end
    nxt();
    cmp("pass", 12'(CONV), 12'(ts - t0));
    lat = 4'h1;
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h05);
    for (int k = 0; k < 5; k++)
    begin
      wr(OS, `DMAL_TCO_FIRST + 8'(te[k]), 8'(2 * k + 2));
      temp_val = 12'(tv[k]);
      wt(2 * CONV);
      cmp("comp", 12'(tv[k] + 2 * k + 2), 12'(comp_temp_r));
    end
    chk(US, `DMAL_TEMP_MSB, 8'h19);
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h07);
    wt(2 * CONV);
    chk(US, `DMAL_TEMP_MSB, 8'h1E);
    chk(US, `DMAL_RX_MSB, 8'hAB);
    chk(US, `DMAL_RX_LSB, 8'hC0);
    chk(US, `DMAL_AUX_RES, 8'hA5);
    chk(US, `DMAL_MPD_RES, 8'hA5);
    chk(US, `DMAL_BIAS_RES, 8'hA5);
    // whole-degree mode: result doubled into half-degree units
    wr(OS, `DMAL_OEM_CONFIG_4, 8'h00);
    wt(2 * CONV);
    chk(US, `DMAL_TEMP_MSB, 8'h32);
    chk(US, `DMAL_TEMP_LSB, 8'h00);
    cmp("comp", 12'h064, 12'(comp_temp_r));
    close_out();
  end
endmodule : tb

`default_nettype wire
